/* hw/lcm_consist_mgr.sv */
// Purpose: Pairing and multi-unit consist control of a handheld throttle
// Assumes: Key inputs are one-cycle pulses, status inputs are levels
// Notes: At most one of the six decoded keys is taken per cycle, lowest key bit first
`timescale 1ns/1ps
module lcm_consist_mgr import lcm_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Locomotive selection
  input wire logic sel_i,
  input wire logic sel_slot_i,
  input wire lcm_addr_t sel_addr_i,
  input wire lcm_res_t sel_res_i,
  input wire logic swap_i,
  // Operation and function keys
  input wire logic speed_key_i,
  input wire lcm_step_t speed_step_i,
  input wire logic dir_i,
  input wire logic func_key_i,
  input wire logic [3:0] func_num_i,
  input wire logic func_on_i,
  input wire logic minus_held_i,
  // Pairing and menu keys
  input wire logic pair_key_i,
  input wire logic unpair_key_i,
  input wire logic enter_key_i,
  input wire logic abort_key_i,
  input wire logic clear_entry_key_i,
  // Multi-unit consist keys
  input wire logic mu_add_key_i,
  input wire logic mu_remove_key_i,
  input wire logic [6:0] mu_addr_i,
  input wire logic mu_show_i,
  // Command station status per slot
  input wire logic [1:0] foreign_i,
  input wire logic [1:0] member_elsewhere_i,
  // Track commands
  output logic cmd_valid_o,
  output lcm_cmd_t cmd_o,
  // Display
  output lcm_disp_t disp_o
);
  // ----------------------------------------------------------------
  // State and wiring
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_ERR, ST_RM_ASK, ST_SECOND} lcm_state_t;
  lcm_state_t state;
  logic [7:0] err_code;
  lcm_slot_t [1:0] slot;
  logic [1:0] load, mark, spd_we;
  lcm_step_t [1:0] spd_v;
  logic cur, oth, last_sel, shown, paired;
  logic [1:0] in_mu;
  logic [6:0] mu_addr;
  logic [3:0] mu_count;
  logic [1:0][7:0] chk;
  logic [7:0] pair_err, mu_err, fail_code;
  logic [5:0] keys, first;
  logic run, mu_view, fail;
  logic do_speed, do_func, do_pair, do_mu_add, do_mu_rem, do_unpair;

  // Top step of a resolution
  function automatic lcm_step_t max_of(input lcm_res_t r);
    lcm_step_t m;
    unique case (r)
      RES_14: m = MAX_14;
      RES_27: m = MAX_27;
      RES_28: m = MAX_28;
      RES_128: m = MAX_128;
    endcase
    return m;
  endfunction : max_of

  // Rescale a step between resolutions; truncates, so stop stays stop
  function automatic lcm_step_t conv(input lcm_step_t s, input lcm_res_t f,
                                     input lcm_res_t t);
    logic [13:0] p;
    logic [13:0] q;
    p = {7'h00, s} * {7'h00, max_of(t)};
    q = p / {7'h00, max_of(f)};
    return q[6:0];
  endfunction : conv

  // ----------------------------------------------------------------
  // Locomotive memories
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_slot
    lcm_slot u_slot (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(load[g]),
      .addr_i(sel_addr_i),
      .res_i(sel_res_i),
      .mark_i(mark[g]),
      .spd_we_i(spd_we[g]),
      .spd_i(spd_v[g]),
      .dir_i(dir_i),
      .slot_o(slot[g])
    );
  end

  // ----------------------------------------------------------------
  // Key decode
  // ----------------------------------------------------------------
  // Lowest set bit wins, so no two of the six decoded keys act in one cycle; select and swap still can
  assign oth = ~cur;
  assign run = (state == ST_RUN);
  assign mu_view = mu_show_i && (mu_count != 4'h0);
  assign keys = {unpair_key_i, mu_remove_key_i, mu_add_key_i, pair_key_i,
                 func_key_i, speed_key_i} & {6{run}};
  assign first = keys & (~keys + 6'h01);
  assign do_speed = first[0];
  assign do_func = first[1] && !mu_view;
  assign do_pair = first[2] && !paired && (pair_err == ERR_NONE);
  assign do_mu_add = first[3] && (mu_err == ERR_NONE) && (mu_count != MU_CNT_MAX);
  assign do_mu_rem = first[4] && in_mu[cur];
  assign do_unpair = first[5] && paired;
  // A pair key while already paired reports its members as taken
  assign fail = (first[2] && (pair_err != ERR_NONE)) ||
                (first[3] && (mu_err != ERR_NONE));
  assign fail_code = first[2] ? pair_err : mu_err;

  // ----------------------------------------------------------------
  // Formation checks
  // ----------------------------------------------------------------
  // Order fixes which code shows when several checks fail at once
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (slot[i].addr == ANALOG_ADDR) begin
        chk[i] = ERR_ADDR0;
      end else if (!slot[i].used) begin
        chk[i] = ERR_NOT_USED;
      end else if (foreign_i[i]) begin
        chk[i] = ERR_FOREIGN;
      end else if (member_elsewhere_i[i] || in_mu[i] || paired) begin
        chk[i] = ERR_MEMBER;
      end else if (slot[i].spd != SPD_STOP) begin
        chk[i] = ERR_MOVING;
      end else begin
        chk[i] = ERR_NONE;
      end
    end
  end

  // First failing slot reports; consist address range checked on first join
  assign pair_err = (chk[0] != ERR_NONE) ? chk[0] : chk[1];
  assign mu_err = ((mu_count == 4'h0) && ((mu_addr_i < MU_ADDR_MIN) ||
                  (mu_addr_i > MU_ADDR_MAX))) ? ERR_MU_ADDR : chk[cur];

  // ----------------------------------------------------------------
  // Slot update controls
  // ----------------------------------------------------------------
  // A paired slot cannot be reloaded, which would break the pairing
  always_comb begin
    load = 2'b00;
    mark = 2'b00;
    spd_we = 2'b00;
    spd_v[0] = slot[0].spd;
    spd_v[1] = slot[1].spd;
    if (sel_i && run && !paired) begin
      load[sel_slot_i] = 1'b1;
    end
    if (do_speed) begin
      mark[cur] = 1'b1;
      spd_we[cur] = 1'b1;
      spd_v[cur] = speed_step_i;
      if (paired) begin
        mark[oth] = 1'b1;
        spd_we[oth] = 1'b1;
        spd_v[oth] = conv(speed_step_i, slot[cur].res, slot[oth].res);
      end
    end
    if (do_func) begin
      mark[cur] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control sequence
  // ----------------------------------------------------------------
  // Error holds every key but clear-entry; removal waits for confirm
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_RUN;
      err_code <= ERR_NONE;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (fail) begin
            state <= ST_ERR;
            err_code <= fail_code;
          end else if (do_speed && paired) begin
            state <= ST_SECOND;
          end else if (do_unpair) begin
            state <= ST_RM_ASK;
          end
        end
        ST_ERR: begin
          if (clear_entry_key_i) begin
            state <= ST_RUN;
            err_code <= ERR_NONE;
          end
        end
        ST_RM_ASK: begin
          if (abort_key_i || enter_key_i) begin
            state <= ST_RUN;
          end
        end
        ST_SECOND: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pairing and view
  // ----------------------------------------------------------------
  // Abort beats a confirm in the same cycle, keeping the pair
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      paired <= 1'b0;
    end else if (do_pair) begin
      paired <= 1'b1;
    end else if ((state == ST_RM_ASK) && enter_key_i && !abort_key_i) begin
      paired <= 1'b0;
    end
  end

  // Slot on view follows selection, swap, and the first-added loco
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur <= 1'b0;
      last_sel <= 1'b0;
    end else if (|load) begin
      cur <= sel_slot_i;
      last_sel <= sel_slot_i;
    end else if (do_pair) begin
      cur <= ~last_sel;
    end else if (run && swap_i) begin
      cur <= ~cur;
    end
  end

  // ----------------------------------------------------------------
  // Multi-unit consist
  // ----------------------------------------------------------------
  // Reloading a slot forgets local membership; the station still knows it
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      in_mu <= 2'b00;
      mu_count <= 4'h0;
      mu_addr <= MU_ADDR_NONE;
    end else begin
      if (do_mu_add) begin
        in_mu[cur] <= 1'b1;
        mu_count <= mu_count + 4'h1;
        if (mu_count == 4'h0) begin
          mu_addr <= mu_addr_i;
        end
      end else if (do_mu_rem) begin
        in_mu[cur] <= 1'b0;
        mu_count <= mu_count - 4'h1;
        if (mu_count == 4'h1) begin
          mu_addr <= MU_ADDR_NONE;
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (load[i]) begin
          in_mu[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Track commands
  // ----------------------------------------------------------------
  // Second pair command reads the slot already rescaled last cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o <= CMD_RST;
    end else begin
      cmd_valid_o <= 1'b0;
      if (state == ST_SECOND) begin
        cmd_valid_o <= 1'b1;
        cmd_o.kind <= CMD_SPEED;
        cmd_o.addr <= slot[oth].addr;
        cmd_o.spd <= slot[oth].spd;
        cmd_o.dir <= slot[oth].dir;
      end else if (do_speed) begin
        cmd_valid_o <= 1'b1;
        cmd_o.kind <= CMD_SPEED;
        cmd_o.dir <= dir_i;
        if (in_mu[cur] || mu_view) begin
          cmd_o.addr <= {7'h00, mu_addr};
          cmd_o.spd <= conv(speed_step_i, slot[cur].res, RES_28);
        end else begin
          cmd_o.addr <= slot[cur].addr;
          cmd_o.spd <= speed_step_i;
        end
      end else if (do_func) begin
        cmd_valid_o <= 1'b1;
        cmd_o.kind <= CMD_FUNC;
        cmd_o.addr <= slot[cur].addr;
        cmd_o.func_num <= func_num_i;
        cmd_o.func_on <= func_on_i;
      end else if (do_mu_add) begin
        cmd_valid_o <= 1'b1;
        cmd_o.kind <= CMD_MU_SET;
        cmd_o.addr <= slot[cur].addr;
        cmd_o.mu_addr <= (mu_count == 4'h0) ? mu_addr_i : mu_addr;
      end else if (do_mu_rem) begin
        cmd_valid_o <= 1'b1;
        cmd_o.kind <= CMD_MU_CLEAR;
        cmd_o.addr <= slot[cur].addr;
        cmd_o.mu_addr <= mu_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Display
  // ----------------------------------------------------------------
  assign shown = (paired && minus_held_i) ? oth : cur;

  // Registered so the panel never sees decode glitches
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      disp_o <= DISP_RST;
    end else if (state == ST_ERR) begin
      disp_o.ind <= IND_ERROR;
      disp_o.err <= err_code;
      disp_o.show_func <= 1'b0;
    end else if (mu_view) begin
      disp_o.ind <= IND_MU;
      disp_o.addr <= {7'h00, mu_addr};
      disp_o.err <= ERR_NONE;
      disp_o.show_func <= 1'b0;
    end else begin
      disp_o.ind <= paired ? IND_PAIR : (in_mu[shown] ? IND_MEMBER : IND_SINGLE);
      disp_o.addr <= slot[shown].addr;
      disp_o.spd <= slot[shown].spd;
      disp_o.dir <= slot[shown].dir;
      disp_o.err <= ERR_NONE;
      disp_o.show_func <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_pair_speed;
    do_speed && paired;
  endsequence
  sequence s_both_sent;
    (cmd_valid_o && (cmd_o.addr == $past(slot[cur].addr))) ##1
    (cmd_valid_o && (cmd_o.addr == slot[oth].addr));
  endsequence
  sequence s_ask_abort;
    (state == ST_RM_ASK) && abort_key_i;
  endsequence

  AST_PAIR_BOTH: assert property (s_pair_speed |-> ##1 s_both_sent)
    else $error("pair speed not sent to both members");
  AST_FUNC_SHOWN: assert property (do_func |=> cmd_valid_o && (cmd_o.kind == CMD_FUNC)
    && (cmd_o.addr == $past(slot[cur].addr)))
    else $error("function command not sent to shown loco");
  AST_FAIL_QUIET: assert property (fail |=> !cmd_valid_o && (state == ST_ERR)
    && $stable(paired) && $stable(mu_count))
    else $error("failed formation changed state or sent command");
  AST_ERR_UNUSED: assert property (first[2] && !paired && (pair_err == ERR_NOT_USED)
    |=> (err_code == ERR_NOT_USED) ##1 (disp_o.err == ERR_NOT_USED))
    else $error("unused candidate did not show error 24");
  AST_ERR_MOVING: assert property (first[2] && !paired && (pair_err == ERR_MOVING)
    |=> (state == ST_ERR) && !paired)
    else $error("moving candidate was paired");
  AST_CLEAR: assert property ((state == ST_ERR) && clear_entry_key_i
    |=> (state == ST_RUN) ##1 (disp_o.ind != IND_ERROR))
    else $error("clear-entry did not leave error display");
  AST_ABORT: assert property (s_ask_abort |=> paired [*2])
    else $error("abort lost the pairing");
  AST_UNPAIR: assert property ((state == ST_RM_ASK) && enter_key_i && !abort_key_i
    |=> !paired ##1 (disp_o.ind != IND_PAIR))
    else $error("confirmed removal kept the pairing");
  AST_MU_RANGE: assert property (cmd_valid_o && (cmd_o.kind == CMD_MU_SET)
    |-> (cmd_o.mu_addr >= MU_ADDR_MIN) && (cmd_o.mu_addr <= MU_ADDR_MAX))
    else $error("consist address out of range");
  AST_MU_SPEED: assert property (do_speed && in_mu[cur]
    |=> cmd_valid_o && (cmd_o.addr == {7'h00, $past(mu_addr)}))
    else $error("member speed not sent to consist address");
  AST_MU_NOFUNC: assert property (run && mu_view && func_key_i && !speed_key_i
    |=> !cmd_valid_o ##1 !disp_o.show_func)
    else $error("function accepted on consist address");
  AST_MU_LAST: assert property (do_mu_rem && (mu_count == 4'h1)
    |=> (mu_count == 4'h0) && (mu_addr == MU_ADDR_NONE))
    else $error("consist kept after last member left");
endmodule : lcm_consist_mgr

/* hw/lcm_pkg.sv */
// Purpose: Shared types and constants of the consist manager
// Assumes: Addresses up to 9999, speed steps in the locomotive's own resolution
// Notes: Error codes match the numbers shown on the throttle display
package lcm_pkg;
  // ----------------------------------------------------------------
  // Widths and basic values
  // ----------------------------------------------------------------
  typedef logic [13:0] lcm_addr_t;
  typedef logic [6:0] lcm_step_t;
  localparam lcm_addr_t ANALOG_ADDR = 14'h0000;
  localparam lcm_step_t SPD_STOP = 7'h00;
  localparam logic [6:0] MU_ADDR_MIN = 7'h01;
  localparam logic [6:0] MU_ADDR_MAX = 7'h63;
  localparam logic [6:0] MU_ADDR_NONE = 7'h00;
  localparam logic [3:0] MU_CNT_MAX = 4'hF;

  // ----------------------------------------------------------------
  // Displayed error codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_NOT_USED = 8'h18;
  localparam logic [7:0] ERR_FOREIGN = 8'h19;
  localparam logic [7:0] ERR_MEMBER = 8'h1A;
  localparam logic [7:0] ERR_MOVING = 8'h1B;
  localparam logic [7:0] ERR_ADDR0 = 8'h1C;
  localparam logic [7:0] ERR_MU_ADDR = 8'h1D;

  // ----------------------------------------------------------------
  // Speed-step resolutions and their top steps
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RES_14, RES_27, RES_28, RES_128} lcm_res_t;
  localparam lcm_step_t MAX_14 = 7'h0E;
  localparam lcm_step_t MAX_27 = 7'h1B;
  localparam lcm_step_t MAX_28 = 7'h1C;
  localparam lcm_step_t MAX_128 = 7'h7E;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CMD_SPEED, CMD_FUNC, CMD_MU_SET, CMD_MU_CLEAR} lcm_kind_t;
  typedef struct packed {
    lcm_kind_t kind;
    lcm_addr_t addr;
    logic dir;
    lcm_step_t spd;
    logic [3:0] func_num;
    logic func_on;
    logic [6:0] mu_addr;
  } lcm_cmd_t;

  typedef enum logic [2:0] {IND_SINGLE, IND_PAIR, IND_MU, IND_MEMBER, IND_ERROR} lcm_ind_t;
  typedef struct packed {
    lcm_ind_t ind;
    lcm_addr_t addr;
    lcm_step_t spd;
    logic dir;
    logic [7:0] err;
    logic show_func;
  } lcm_disp_t;

  typedef struct packed {
    lcm_addr_t addr;
    lcm_res_t res;
    logic used;
    lcm_step_t spd;
    logic dir;
  } lcm_slot_t;

  localparam lcm_slot_t SLOT_RST = '{addr: ANALOG_ADDR, res: RES_28, used: 1'b0,
                                     spd: SPD_STOP, dir: 1'b0};
  localparam lcm_cmd_t CMD_RST = '{kind: CMD_SPEED, addr: ANALOG_ADDR, dir: 1'b0,
                                   spd: SPD_STOP, func_num: 4'h0, func_on: 1'b0,
                                   mu_addr: MU_ADDR_NONE};
  localparam lcm_disp_t DISP_RST = '{ind: IND_SINGLE, addr: ANALOG_ADDR, spd: SPD_STOP,
                                     dir: 1'b0, err: ERR_NONE, show_func: 1'b1};
endpackage : lcm_pkg

/* hw/lcm_slot.sv */
// Purpose: One locomotive memory of the throttle
// Assumes: Load wins over any update in the same cycle
// Notes: A freshly loaded locomotive counts as never commanded
`timescale 1ns/1ps
module lcm_slot import lcm_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Load a new locomotive
  input wire logic load_i,
  input wire lcm_addr_t addr_i,
  input wire lcm_res_t res_i,
  // Updates from operation keys
  input wire logic mark_i,
  input wire logic spd_we_i,
  input wire lcm_step_t spd_i,
  input wire logic dir_i,
  // Stored state
  output lcm_slot_t slot_o
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Speed starts at stop, so a new pairing candidate is not refused as moving
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slot_o <= SLOT_RST;
    end else if (load_i) begin
      slot_o.addr <= addr_i;
      slot_o.res <= res_i;
      slot_o.used <= 1'b0;
      slot_o.spd <= SPD_STOP;
      slot_o.dir <= 1'b0;
    end else begin
      if (mark_i) begin
        slot_o.used <= 1'b1;
      end
      if (spd_we_i) begin
        slot_o.spd <= spd_i;
        slot_o.dir <= dir_i;
      end
    end
  end
endmodule : lcm_slot

/* tb/lcm_consist_mgr_tb.sv */
// Purpose: Self-checking bench of the consist manager
// Assumes: Keys are pulsed 1 ns after a rising edge
// Notes: Track commands are queued by a monitor and checked in order
`timescale 1ns/1ps
module lcm_consist_mgr_tb import lcm_pkg::*;;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sel_i, sel_slot_i, swap_i, speed_key_i, dir_i, func_key_i, func_on_i, minus_held_i;
  logic pair_key_i, unpair_key_i, enter_key_i, abort_key_i, clear_entry_key_i;
  logic mu_add_key_i, mu_remove_key_i, mu_show_i, cmd_valid_o;
  logic [1:0] foreign_i, member_elsewhere_i, other_hh;
  logic [3:0] func_num_i;
  logic [6:0] mu_addr_i;
  lcm_addr_t sel_addr_i, loco0, loco1;
  lcm_res_t sel_res_i;
  lcm_step_t speed_step_i;
  lcm_cmd_t cmd_o;
  lcm_disp_t disp_o;
  lcm_cmd_t cq[$];
  int num_errors = 0;
  int samples_checked = 0;

  lcm_consist_mgr DUT (.ref_clk_i, .sys_rst_i, .sel_i, .sel_slot_i, .sel_addr_i, .sel_res_i,
    .swap_i, .speed_key_i, .speed_step_i, .dir_i, .func_key_i, .func_num_i, .func_on_i,
    .minus_held_i, .pair_key_i, .unpair_key_i, .enter_key_i, .abort_key_i,
    .clear_entry_key_i, .mu_add_key_i, .mu_remove_key_i, .mu_addr_i, .mu_show_i,
    .foreign_i, .member_elsewhere_i, .cmd_valid_o, .cmd_o, .disp_o);
  lcm_station_model STN (.ref_clk_i, .sys_rst_i, .cmd_valid_i(cmd_valid_o), .cmd_i(cmd_o),
    .loco0_i(loco0), .loco1_i(loco1), .other_hh_i(other_hh), .foreign_o(foreign_i),
    .member_o(member_elsewhere_i));

  // ----------------------------------------------------------------
  // Clock, command monitor and access tasks
  // ----------------------------------------------------------------
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (cmd_valid_o === 1'b1) cq.push_back(cmd_o);

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  // Three idle edges let both pair commands and error display land
  task automatic press(ref logic k);
    k = 1'b1;
    tick(1);
    k = 1'b0;
    tick(3);
  endtask : press
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic chk_cmd(input lcm_kind_t k, input lcm_addr_t a, input logic [6:0] v);
    lcm_cmd_t c;
    chk("cmd present", 1'b1, cq.size() > 0);
    if (cq.size() > 0) begin
      c = cq.pop_front();
      chk("cmd kind", k, c.kind);
      chk("cmd addr", a, c.addr);
      if (k == CMD_SPEED) chk("cmd spd", v, c.spd);
      if (k == CMD_FUNC) chk("cmd func", v, c.func_num);
      if (k == CMD_MU_SET) chk("cmd mu", v, c.mu_addr);
    end
  endtask : chk_cmd
  task automatic load(input logic s, input lcm_addr_t a, input lcm_res_t r);
    sel_slot_i = s;
    sel_addr_i = a;
    sel_res_i = r;
    if (s) loco1 = a;
    else loco0 = a;
    press(sel_i);
  endtask : load
  task automatic spd(input lcm_step_t s);
    speed_step_i = s;
    press(speed_key_i);
  endtask : spd
  task automatic fail(ref logic k, input logic [7:0] e);
    press(k);
    chk("err code", e, disp_o.err);
    chk("err ind", IND_ERROR, disp_o.ind);
    press(clear_entry_key_i);
    chk("err cleared", 1'b1, disp_o.ind !== IND_ERROR);
    chk("no cmd", 0, cq.size());
  endtask : fail
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {sel_i, sel_slot_i, swap_i, speed_key_i, dir_i, func_key_i, func_on_i} = '0;
    {minus_held_i, pair_key_i, unpair_key_i, enter_key_i, abort_key_i} = '0;
    {clear_entry_key_i, mu_add_key_i, mu_remove_key_i, mu_show_i, other_hh} = '0;
    {func_num_i, mu_addr_i, sel_addr_i, loco0, loco1, speed_step_i} = '0;
    sel_res_i = RES_28;
    repeat (10) @(posedge ref_clk_i);
    chk("reset disp", DISP_RST, disp_o);
    chk("reset valid", 1'b0, cmd_valid_o);
    #1 sys_rst_i = 1'b0;
    tick(2);
    load(1'b0, ANALOG_ADDR, RES_28);
    load(1'b1, 14'h004E, RES_28);
    fail(pair_key_i, ERR_ADDR0);
    load(1'b0, 14'h0018, RES_14);
    fail(pair_key_i, ERR_NOT_USED);
    spd(7'h00);
    chk_cmd(CMD_SPEED, 14'h0018, 7'h00);
    press(swap_i);
    spd(7'h03);
    chk_cmd(CMD_SPEED, 14'h004E, 7'h03);
    other_hh = 2'h2;
    fail(pair_key_i, ERR_FOREIGN);
    other_hh = 2'h0;
    fail(pair_key_i, ERR_MOVING);
    spd(7'h00);
    chk_cmd(CMD_SPEED, 14'h004E, 7'h00);
    press(pair_key_i);
    chk("pair ind", IND_PAIR, disp_o.ind);
    chk("pair addr", 14'h004E, disp_o.addr);
    fail(pair_key_i, ERR_MEMBER);
    chk("pair kept", IND_PAIR, disp_o.ind);
    press(swap_i);
    dir_i = 1'b1;
    spd(7'h0E);
    chk_cmd(CMD_SPEED, 14'h0018, 7'h0E);
    chk_cmd(CMD_SPEED, 14'h004E, 7'h1C);
    chk("shown step", 7'h0E, disp_o.spd);
    press(swap_i);
    chk("other step", 7'h1C, disp_o.spd);
    press(swap_i);
    func_num_i = 4'h3;
    func_on_i = 1'b1;
    press(func_key_i);
    chk_cmd(CMD_FUNC, 14'h0018, 7'h03);
    chk("one func cmd", 0, cq.size());
    minus_held_i = 1'b1;
    tick(3);
    chk("minus addr", 14'h004E, disp_o.addr);
    minus_held_i = 1'b0;
    press(unpair_key_i);
    press(abort_key_i);
    chk("abort kept", IND_PAIR, disp_o.ind);
    press(unpair_key_i);
    press(enter_key_i);
    chk("unpaired ind", IND_SINGLE, disp_o.ind);
    spd(7'h00);
    chk_cmd(CMD_SPEED, 14'h0018, 7'h00);
    mu_addr_i = 7'h00;
    fail(mu_add_key_i, ERR_MU_ADDR);
    mu_addr_i = 7'h64;
    fail(mu_add_key_i, ERR_MU_ADDR);
    mu_addr_i = 7'h63;
    press(mu_add_key_i);
    chk_cmd(CMD_MU_SET, 14'h0018, 7'h63);
    spd(7'h07);
    chk_cmd(CMD_SPEED, 14'h0063, 7'h0E);
    chk("decoder step", 7'h0E, STN.spd_of[14'h0018]);
    mu_show_i = 1'b1;
    tick(3);
    chk("mu ind", IND_MU, disp_o.ind);
    chk("mu no func", 1'b0, disp_o.show_func);
    press(func_key_i);
    chk("mu func dropped", 0, cq.size());
    press(mu_remove_key_i);
    chk_cmd(CMD_MU_CLEAR, 14'h0018, 7'h00);
    chk("consist gone", 1'b1, disp_o.ind !== IND_MU);
    chk("decoder freed", 2'h0, member_elsewhere_i);
    test_done();
  end

  // Watchdog well beyond the under two hundred cycles the scenarios need
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    num_errors++;
    test_done();
  end
endmodule : lcm_consist_mgr_tb

/* tb/lcm_station_model.sv */
// Purpose: Command station and track decoders seen by the consist manager
// Assumes: One track command per cycle, no back-pressure
// Notes: Decoder state is kept per address in associative tables
`timescale 1ns/1ps
module lcm_station_model import lcm_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Track commands
  input wire logic cmd_valid_i,
  input wire lcm_cmd_t cmd_i,
  // Locos held by the throttle, other handheld ownership
  input wire lcm_addr_t loco0_i,
  input wire lcm_addr_t loco1_i,
  input wire logic [1:0] other_hh_i,
  // Status to the throttle
  output logic [1:0] foreign_o,
  output logic [1:0] member_o
);
  logic [6:0] mu_of [lcm_addr_t];
  lcm_step_t spd_of [lcm_addr_t];

  // Ownership comes straight from the other handhelds
  assign foreign_o = other_hh_i;

  // Decoders react to each track command
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mu_of.delete();
      member_o <= 2'h0;
    end else begin
      if (cmd_valid_i === 1'b1 && cmd_i.kind == CMD_MU_SET) begin
        mu_of[cmd_i.addr] = cmd_i.mu_addr;
      end
      if (cmd_valid_i === 1'b1 && cmd_i.kind == CMD_MU_CLEAR) begin
        mu_of.delete(cmd_i.addr);
      end
      if (cmd_valid_i === 1'b1 && cmd_i.kind == CMD_SPEED) begin
        // Own address is deaf to speed while a consist address is held
        if (!mu_of.exists(cmd_i.addr)) spd_of[cmd_i.addr] = cmd_i.spd;
        foreach (mu_of[a]) if (cmd_i.addr == {7'h00, mu_of[a]}) spd_of[a] = cmd_i.spd;
      end
      member_o <= {mu_of.exists(loco1_i), mu_of.exists(loco0_i)};
    end
  end
endmodule : lcm_station_model
